// *** hw/edge_clock_divider.sv ***
// Edge clock divider top with APB control and loop-side signals.
//
// Contract
// - Divided clock runs at one half, quarter or eighth of the source.
// - Divided clock phase is fixed by the release after reset.
// - Divider reset clears the count and forces outputs low at once; the code forces only divClockOut low, not loopDiv3Out.
// - Outputs toggle only after release, first leaving low on a source edge; loopDiv3Out toggles whether or not release is set.
// - Source is the loop, slave delay, fabric routing or external clock.
// - Loop reset high resets the loop counters and dividers.
// - Lock indication reads high when the loop has locked to its reference.
// - A loop output carries the primary loop output divided by three.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`include "edge_div_cfg.svh"
`default_nettype none
module edge_clock_divider (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source pins, sampled through two flip-flops.
  input wire logic loopPrimaryOut,
  input wire logic slaveDelayIn,
  input wire logic fabricClockIn,
  input wire logic extClockIn,
  input wire logic loopLock,
  // Loop control and clock outputs.
  output logic loopReset,
  output logic divClockOut,
  output logic loopDiv3Out
);
  import edge_div_pkg::*;

  // ==========================================================
  // Address decode
  // Returns 0 for control, 1 for status, 2 for anything unmapped.
  function automatic logic [1:0] regIndex(input logic [11:0] addr);
    if (addr == `CTRL_OFS)
    begin
      return 2'h0;
    end
    else if (addr == `STATUS_OFS)
    begin
      return 2'h1;
    end
    return 2'h2;
  endfunction

  div_link_if link ();

  logic [`CTRL_USED_BITS-1:0] ctrl;
  logic [`CTRL_USED_BITS-1:0] next_ctrl;
  logic [31:0] next_prdata;
  logic [31:0] status;
  logic [`PIN_COUNT-1:0] pinRaw;
  logic [`PIN_COUNT-1:0] syncA;
  logic [`PIN_COUNT-1:0] syncB;
  logic [`PIN_COUNT-1:0] syncC;
  logic [`PIN_COUNT-1:0] pinEdge;
  logic [3:0] srcEdges;
  logic setupPhase;
  logic accessPhase;
  logic writeCtrl;
  source_e srcSel;
  logic selEdge;
  logic lockSeen;
  logic div3Level;

  // ==========================================================
  // APB phases
  // The slave answers in the first access cycle, so pready is always high.
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign pready = 1'b1;
  assign pslverr = accessPhase && regIndex(paddr) == 2'h2;
  assign writeCtrl = accessPhase && pwrite && regIndex(paddr) == 2'h0;

  // ==========================================================
  // Control register
  // Only the control word is writable; status writes are dropped silently.
  always_comb
  begin
    next_ctrl = ctrl;
    if (writeCtrl)
    begin
      next_ctrl = pwdata[`CTRL_USED_BITS-1:0];
    end
  end

  // Registers the control word.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrl <= `CTRL_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================
  // Read data
  // Read data is captured in the setup cycle and stands through access.
  always_comb
  begin
    next_prdata = prdata;
    if (setupPhase && !pwrite)
    begin
      unique case (regIndex(paddr))
        2'h0: next_prdata = {{(32 - `CTRL_USED_BITS){1'b0}}, ctrl};
        2'h1: next_prdata = status;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Registers the read data.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // Two flops per pin; a third copy of the second flop finds rising edges.
  assign pinRaw = {loopLock, extClockIn, fabricClockIn, slaveDelayIn, loopPrimaryOut};

  // Registers the synchroniser chain.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end
    else
    begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // Rising edges of each synchronised pin.
  assign pinEdge = syncB & ~syncC;
  assign lockSeen = syncB[4];

  // ==========================================================
  // Source selection
  // Edges of the four clock pins, indexed by the source code.
  assign srcEdges = pinEdge[3:0];
  assign srcSel = source_e'(ctrl[`CTRL_SRC_LSB +: 2]);
  assign selEdge = srcEdges[srcSel];

  // ==========================================================
  // Divider steering
  // Software must leave release low until the source is stable.
  assign link.srcEdge = selEdge;
  assign link.outRelease = ctrl[`CTRL_RELEASE_BIT];
  assign link.divReset = ctrl[`CTRL_DIVRST_BIT];
  assign link.ratio = ratio_e'(ctrl[`CTRL_RATIO_LSB +: 2]);

  // Counter that makes the divided clock.
  edge_div_counter divider (
    .clock(clock),
    .rst_n(rst_n),
    .link(link.gen)
  );

  // Divide-by-three copy of the primary loop output.
  loop_div3 third (
    .clock(clock),
    .rst_n(rst_n),
    .loopReset(ctrl[`CTRL_LOOPRST_BIT]),
    .primEdge(pinEdge[0]),
    .div3Out(div3Level)
  );

  // ==========================================================
  // Outputs and status
  assign divClockOut = link.divOut;
  assign loopDiv3Out = div3Level;
  assign loopReset = ctrl[`CTRL_LOOPRST_BIT];

  // Status word built from live divider and loop state.
  always_comb
  begin
    status = 32'h0000_0000;
    status[`STAT_LOCK_BIT] = lockSeen;
    status[`STAT_RUN_BIT] = link.outRelease && !link.divReset;
    status[`STAT_DIV_BIT] = link.divOut;
    status[`STAT_DIV3_BIT] = div3Level;
    status[`STAT_CNT_LSB +: 3] = link.count;
  end

  // ==========================================================
  // Checks
  // A read setup cycle to one offset.
  sequence readSetup(logic [11:0] ofs);
    psel && !penable && !pwrite && paddr == ofs;
  endsequence

  // A write access to the control word.
  sequence ctrlWrite;
    psel && penable && pwrite && paddr == `CTRL_OFS;
  endsequence

  lockRead_a: assert property (@(posedge clock) disable iff (!rst_n)
    readSetup(`STATUS_OFS) |=> prdata[`STAT_LOCK_BIT] == $past(syncB[4]))
    else $error("status lock bit wrong");
  loopResetWrite_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrlWrite |=> loopReset == $past(pwdata[`CTRL_LOOPRST_BIT]))
    else $error("loop reset did not follow write");
  sourceEdge_a: assert property (@(posedge clock) disable iff (!rst_n)
    selEdge && $stable(srcSel) |-> syncB[srcSel] && !$past(syncB[srcSel]))
    else $error("selected edge from wrong source");
  resetPin_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrlWrite and pwdata[`CTRL_DIVRST_BIT] |=> !divClockOut [*2])
    else $error("divided clock high while held in reset");
  unmapped_a: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && paddr != `CTRL_OFS && paddr != `STATUS_OFS |-> pslverr)
    else $error("unmapped access not flagged");
  firstEdge_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(divClockOut) |-> $past(selEdge) && $past(link.outRelease))
    else $error("divided clock left low without release and edge");

  // ==========================================================
  // Register and pin checks
  // A write access that must leave the control word alone.
  sequence droppedWrite;
    psel && penable && pwrite && paddr != `CTRL_OFS;
  endsequence

  // A read setup cycle to an address that holds no register.
  sequence unmappedSetup;
    psel && !penable && !pwrite && paddr != `CTRL_OFS && paddr != `STATUS_OFS;
  endsequence

  // The control word leaves reset at its reset value.
  resetCtrl_a: assert property (@(posedge clock)
    $rose(rst_n) |-> ctrl == `CTRL_RESET)
    else $error("control word not at reset value");

  // A control write lands at its access edge; other writes leave it alone.
  ctrlLands_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrlWrite |=> ctrl == $past(pwdata[`CTRL_USED_BITS-1:0]))
    else $error("control write lost");
  writeDropped_a: assert property (@(posedge clock) disable iff (!rst_n)
    droppedWrite |=> $stable(ctrl))
    else $error("dropped write changed control");

  // Read data of the control word, of unmapped space and of the count field.
  ctrlRead_a: assert property (@(posedge clock) disable iff (!rst_n)
    readSetup(`CTRL_OFS) |=> prdata == {{(32 - `CTRL_USED_BITS){1'b0}}, $past(ctrl)})
    else $error("control read wrong");
  unmappedRead_a: assert property (@(posedge clock) disable iff (!rst_n)
    unmappedSetup |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  countRead_a: assert property (@(posedge clock) disable iff (!rst_n)
    readSetup(`STATUS_OFS) |=> prdata[`STAT_CNT_LSB +: 3] == $past(link.count))
    else $error("status count field wrong");

  // Read data is not reloaded during the access cycle.
  readStands_a: assert property (@(posedge clock) disable iff (!rst_n)
    psel && !penable && !pwrite ##1 psel && penable |=> $stable(prdata))
    else $error("read data moved during access");

  // Pins reach their synchronised copies two edges late.
  lockSync_a: assert property (@(posedge clock) disable iff (!rst_n)
    lockSeen |-> $past(loopLock, 2))
    else $error("lock seen without lock pin");
  pinSync_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(syncB[0]) |-> $past(loopPrimaryOut, 2))
    else $error("primary edge seen without pin");

  // The divided clock returns low once release has been taken away.
  releaseLow_a: assert property (@(posedge clock) disable iff (!rst_n)
    !link.outRelease |=> !divClockOut)
    else $error("divided clock high without release");

  // The loop output only rises on a primary edge outside loop reset.
  div3Edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(loopDiv3Out) |-> $past(pinEdge[0]) && !$past(loopReset))
    else $error("div3 output rose without primary edge");
endmodule
`default_nettype wire

// *** hw/edge_div_cfg.svh ***
// Register offsets, field positions and reset values of the edge clock divider.
`ifndef EDGE_DIV_CFG_SVH
`define EDGE_DIV_CFG_SVH

// Register byte offsets on the APB port.
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004

// Control register field positions.
`define CTRL_RATIO_LSB 0
`define CTRL_SRC_LSB 2
`define CTRL_DIVRST_BIT 4
`define CTRL_RELEASE_BIT 5
`define CTRL_LOOPRST_BIT 6
`define CTRL_USED_BITS 7

// Control register reset value: divider held in reset, outputs not released.
`define CTRL_RESET 7'h10

// Status register field positions.
`define STAT_LOCK_BIT 0
`define STAT_RUN_BIT 1
`define STAT_DIV_BIT 2
`define STAT_DIV3_BIT 3
`define STAT_CNT_LSB 4

// Number of pin inputs that are synchronised.
`define PIN_COUNT 5

`endif

// *** hw/edge_div_pkg.sv ***
// Types and shared helper functions of the edge clock divider.
`default_nettype none
package edge_div_pkg;

  // Divide ratio encodings; the spare code behaves as divide by eight.
  typedef enum logic [1:0] {
    DIV_BY2 = 2'b00,
    DIV_BY4 = 2'b01,
    DIV_BY8 = 2'b10,
    DIV_RSVD = 2'b11
  } ratio_e;

  // Divider input sources.
  typedef enum logic [1:0] {
    SRC_LOOP = 2'b00,
    SRC_SLAVE = 2'b01,
    SRC_FABRIC = 2'b10,
    SRC_EXT = 2'b11
  } source_e;

  // Input edges per half period of the divided clock.
  function automatic logic [2:0] halfEdges(input ratio_e r);
    unique case (r)
      DIV_BY2: return 3'h1;
      DIV_BY4: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

endpackage
`default_nettype wire

// *** hw/div_link_if.sv ***
// Signals between the divider top and its counter.
`default_nettype none
interface div_link_if;
  logic srcEdge;
  logic outRelease;
  logic divReset;
  edge_div_pkg::ratio_e ratio;
  logic divOut;
  logic [2:0] count;

  // The top steers the counter.
  modport ctl (output srcEdge, outRelease, divReset, ratio, input divOut, count);
  // The counter produces the divided clock.
  modport gen (input srcEdge, outRelease, divReset, ratio, output divOut, count);
endinterface
`default_nettype wire

// *** hw/edge_div_counter.sv ***
// Divided clock generator counting edges of the selected source.
`default_nettype none
module edge_div_counter (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Control and divided output.
  div_link_if.gen link
);
  import edge_div_pkg::*;

  logic [2:0] count;
  logic [2:0] next_count;
  logic divLevel;
  logic next_divLevel;

  // ==========================================================
  // Counter
  // Held clear until release, so phase is fixed by the release.
  always_comb
  begin
    next_count = count;
    next_divLevel = divLevel;
    if (link.divReset || !link.outRelease)
    begin
      next_count = 3'h0;
      next_divLevel = 1'b0;
    end
    else if (link.srcEdge)
    begin
      if (count == halfEdges(link.ratio) - 3'h1)
      begin
        next_count = 3'h0;
        next_divLevel = ~divLevel;
      end
      else
      begin
        next_count = count + 3'h1;
      end
    end
  end

  // Registers the counter state.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      count <= 3'h0;
      divLevel <= 1'b0;
    end
    else
    begin
      count <= next_count;
      divLevel <= next_divLevel;
    end
  end

  // Reset forces the output low in the same cycle, with no source edge.
  assign link.divOut = divLevel & ~link.divReset;
  assign link.count = count;

  // ==========================================================
  // Checks
  resetLow_a: assert property (@(posedge clock) disable iff (!rst_n)
    link.divReset |-> !link.divOut) else $error("divided clock high during reset");
  holdLow_a: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(link.outRelease) |-> !divLevel) else $error("divided clock moved before release");
  riseOnEdge_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(divLevel) |-> $past(link.srcEdge)) else $error("divided clock rose without source edge");
  phaseFixed_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(link.outRelease) |-> count == 3'h0 && !divLevel) else $error("phase not cleared at release");
  halfPeriod_a: assert property (@(posedge clock) disable iff (!rst_n)
    link.srcEdge && link.outRelease && !link.divReset && count == halfEdges(link.ratio) - 3'h1
    |=> divLevel != $past(divLevel)) else $error("divided clock missed its toggle");
endmodule
`default_nettype wire

// *** hw/loop_div3.sv ***
// Divide-by-three copy of the primary loop output.
`default_nettype none
module loop_div3 (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Loop control and primary edges.
  input wire logic loopReset,
  input wire logic primEdge,
  // Divided output.
  output logic div3Out
);
  logic [1:0] count;
  logic [1:0] next_count;
  logic next_div3Out;

  // ==========================================================
  // Modulo-three counter, cleared by the loop reset.
  always_comb
  begin
    next_count = count;
    if (loopReset)
    begin
      next_count = 2'h0;
    end
    else if (primEdge)
    begin
      next_count = (count == 2'h2) ? 2'h0 : count + 2'h1;
    end
    next_div3Out = !loopReset && next_count == 2'h0 && (primEdge || div3Out);
  end

  // Registers the counter and output.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      count <= 2'h0;
      div3Out <= 1'b0;
    end
    else
    begin
      count <= next_count;
      div3Out <= next_div3Out;
    end
  end

  // ==========================================================
  // Checks
  div3Rise_a: assert property (@(posedge clock) disable iff (!rst_n)
    primEdge && !loopReset && count == 2'h2 |=> div3Out) else $error("div3 output missed rise");
  loopClear_a: assert property (@(posedge clock) disable iff (!rst_n)
    loopReset |=> !div3Out && count == 2'h0) else $error("loop reset did not clear div3");
endmodule
`default_nettype wire

// *** testbench/clock_source_model.sv ***
// Behavioural model of the loop and the clock sources that feed the divider.
`default_nettype none
module clock_source_model (
  // Clock and loop control.
  input wire logic clock,
  input wire logic loopReset,
  // Source clocks and lock indication.
  output logic [3:0] srcPins,
  output logic loopLock
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase [4] = '{0, 0, 0, 0};
  int lockWait = 20;

  initial srcPins = 4'h0;
  initial loopLock = 1'b0;

  // Source i toggles every 3+i cycles, slow enough for the pin samplers.
  always @(posedge clock)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (phase[i] >= 2 + i)
      begin
        phase[i] <= 0;
        srcPins[i] <= ~srcPins[i];
      end
      else
        phase[i] <= phase[i] + 1;
    end
  end

  // The loop drops lock while held in reset and relocks 20 cycles later.
  always @(posedge clock)
  begin
    if (loopReset === 1'b1)
    begin
      lockWait <= 20;
      loopLock <= 1'b0;
    end
    else if (lockWait > 0)
      lockWait <= lockWait - 1;
    else
      loopLock <= 1'b1;
  end
endmodule
`default_nettype wire

// *** testbench/edge_clock_divider_test.sv ***
// Self-checking bench of the edge clock divider driven over its APB port.
`include "edge_div_cfg.svh"
`default_nettype none
module edge_clock_divider_test;
  import edge_div_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, loopLock, loopReset, divClockOut, loopDiv3Out;
  logic [3:0] srcPins, prevPins = 4'h0;
  logic prevDiv = 1'b0;
  logic prevDiv3 = 1'b0;
  int failCount = 0;
  int nTests = 0;
  int cycle = 0, lastRise = 0, divRise = 0, primRises = 0, div3Rises = 0;
  int sel = 0, t0, t1, refDelta = -1, mul, p, d;

  edge_clock_divider dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loopPrimaryOut(srcPins[0]), .slaveDelayIn(srcPins[1]), .fabricClockIn(srcPins[2]),
    .extClockIn(srcPins[3]), .loopLock(loopLock), .loopReset(loopReset), .divClockOut(divClockOut),
    .loopDiv3Out(loopDiv3Out));

  clock_source_model far (.clock(clock), .loopReset(loopReset), .srcPins(srcPins), .loopLock(loopLock));

  // Clock of 4 ns period.
  always #2 clock = ~clock;

  // Counts cycles, notes edges on sources and outputs, and cuts a hang short.
  always @(posedge clock)
  begin
    cycle <= cycle + 1;
    prevPins <= srcPins;
    prevDiv <= divClockOut;
    prevDiv3 <= loopDiv3Out;
    if (srcPins[sel] && !prevPins[sel]) lastRise <= cycle;
    if (srcPins[0] && !prevPins[0]) primRises <= primRises + 1;
    if (loopDiv3Out === 1'b1 && prevDiv3 === 1'b0) div3Rises <= div3Rises + 1;
    if (divClockOut === 1'b1 && prevDiv === 1'b0) divRise <= cycle;
    if (cycle == 20000)
    begin
      failCount = failCount + 1;
      tally_and_finish();
    end
  end

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int waits = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      waits++;
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready wait states", 32'h0, 32'(waits));
  endtask

  // Compares one value and counts the result.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      failCount++;
    end
  endtask

  // Waits for the next rising edge of the divided clock.
  task automatic waitRise(output int t);
    int old;
    old = divRise;
    @(posedge clock);
    while (divRise == old) @(posedge clock);
    t = divRise;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence of register accesses and output measurements.
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h10, rd);
    chk("div reset low", 32'h0, 32'(divClockOut));
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h002, 32'h7F);
    chk("misaligned err", 32'h1, 32'(err));
    apb(1'b1, `STATUS_OFS, 32'hFF);
    chk("status write err", 32'h0, 32'(err));
    apb(1'b0, `CTRL_OFS, 32'h0);
    chk("ctrl unchanged", 32'h10, rd);
    apb(1'b1, `CTRL_OFS, 32'h50);
    @(posedge clock);
    chk("loop reset pin", 32'h1, 32'(loopReset));
    repeat (4) @(posedge clock);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk("lock dropped", 32'h0, 32'(rd[0]));
    apb(1'b1, `CTRL_OFS, 32'h10);
    for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) apb(1'b0, `STATUS_OFS, 32'h0);
    chk("lock regained", 32'h1, 32'(rd[0]));
    for (int r = 0; r < 4; r++)
      for (int s = 0; s < 4; s++)
      begin
        sel = s;
        mul = (r == 0) ? 2 : (r == 1) ? 4 : 8;
        apb(1'b1, `CTRL_OFS, 32'h10 | 32'(s << 2) | 32'(r));
        repeat (20) @(posedge clock);
        chk("held before release", 32'h0, 32'(divClockOut));
        apb(1'b1, `CTRL_OFS, 32'h20 | 32'(s << 2) | 32'(r));
        waitRise(t0);
        if (refDelta < 0) refDelta = t0 - lastRise;
        chk("release phase", 32'(refDelta), 32'(t0 - lastRise));
        waitRise(t1);
        chk("divided period", 32'(mul * (6 + 2 * s)), 32'(t1 - t0));
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk("running flag", 32'h1, 32'(rd[1]));
      end
    while (divClockOut !== 1'b1) @(posedge clock);
    apb(1'b1, `CTRL_OFS, 32'h1F);
    @(posedge clock);
    chk("forced low", 32'h0, 32'(divClockOut));
    t0 = divRise;
    repeat (30) @(posedge clock);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk("count cleared", 32'h0, 32'({rd[6:4], rd[2:1]}));
    chk("no toggles", 32'(t0), 32'(divRise));
    p = primRises;
    d = div3Rises;
    repeat (300) @(posedge clock);
    p = primRises - p;
    d = div3Rises - d;
    chk("div3 rate", 32'h1, 32'(3 * d >= p - 3 && 3 * d <= p + 3));
    apb(1'b1, `CTRL_OFS, 32'h5F);
    repeat (3) @(posedge clock);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clock);
      chk("div3 in loop reset", 32'h0, 32'(loopDiv3Out));
    end
    apb(1'b1, `CTRL_OFS, 32'h10);
    tally_and_finish();
  end
endmodule
`default_nettype wire
